/* rtl/scr_pkg.sv */
// scr_pkg: constants shared by both ends of the sync character receiver
// assumes: one clk_sys domain for the parallel side, 32-bit apb on the host
package scr_pkg;

  // ----------------------------------------------------------------
  // character format
  // ----------------------------------------------------------------
  localparam int CHAR_MAX = 8;
  localparam logic [3:0] CHAR_MIN_LEN = 4'h5;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // control byte layout (captured by the config load strobe)
  // ----------------------------------------------------------------
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_PAR_OFF = 2;
  localparam int CFG_PAR_EVEN = 3;
  localparam int CFG_MODE_LSB = 4;
  localparam logic [2:0] MODE_SYNC_INT = 3'h7;
  localparam logic [7:0] CFG_RESET = 8'h77;
  localparam logic [7:0] MATCH_RESET = 8'h00;

  // ----------------------------------------------------------------
  // host register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_MATCH = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_DISABLE = 0;
  localparam int CTRL_MCLEAR = 1;
  localparam int CMD_LOAD_CFG = 0;
  localparam int CMD_LOAD_MATCH = 1;
  localparam int CMD_CLR_ERR = 2;
  localparam int CMD_CLR_RX = 3;
  localparam int IRQ_RX = 0;
  localparam int IRQ_SYNC = 1;
  localparam int IRQ_ERR = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [1:0] {
    SCR_HUNT = 2'b00,
    SCR_LOCKED = 2'b01
  } scr_state_e;

endpackage : scr_pkg

/* rtl/scr_link_if.sv */
// scr_link_if: parallel side between the receiver and its control logic
// assumes: every signal changes on clk_sys; outputs of the receiver that
// can float come with an enable, high while the receiver drives them
interface scr_link_if;
  logic [2:0] rx_mode_select;
  logic [7:0] sync_match_value;
  logic [1:0] char_length_select;
  logic parity_off;
  logic parity_even_select;
  logic config_load_strobe;
  logic sync_match_load;
  logic error_flags_clear_n;
  logic char_received_clear_n;
  logic chip_io_disable;
  logic master_clear;
  logic [8:0] rx_char_out;
  logic parity_err_flag;
  logic framing_err_flag;
  logic overrun_err_flag;
  logic out_oe;
  logic char_received_flag;
  logic sync_found;

  modport dev (
    input rx_mode_select, sync_match_value, char_length_select, parity_off,
    input parity_even_select, config_load_strobe, sync_match_load,
    input error_flags_clear_n, char_received_clear_n, chip_io_disable,
    input master_clear,
    output rx_char_out, parity_err_flag, framing_err_flag, overrun_err_flag,
    output out_oe, char_received_flag, sync_found
  );

  modport host (
    output rx_mode_select, sync_match_value, char_length_select, parity_off,
    output parity_even_select, config_load_strobe, sync_match_load,
    output error_flags_clear_n, char_received_clear_n, chip_io_disable,
    output master_clear,
    input rx_char_out, parity_err_flag, framing_err_flag, overrun_err_flag,
    input out_oe, char_received_flag, sync_found
  );
endinterface : scr_link_if

/* rtl/scr_sync.sv */
// scr_sync: two-flop synchroniser for pin levels, rising edge of bit 0
// assumes: inputs are asynchronous to clk_sys
module scr_sync
  import scr_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q[0];
    end
  end

  assign q = sync_q;
  assign rise = sync_q[0] & ~prev_q;
endmodule : scr_sync

/* rtl/scr_receiver.sv */
// scr_receiver: character-synchronising serial receiver (device end)
// assumes: bit clock and serial data arrive from a modem, asynchronous to
// clk_sys; the parallel side is driven by control logic on clk_sys
//
// Operation
// - accept back-to-back characters, no start/stop bits
// - frame fixed-length characters by sync pattern match
// - internal or external sync chosen by config
// - host selects internal sync mode; here the mode comes from CFG bits 6:4, internal sync at reset
// - mode select captured by config load strobe
// - mode select all high means internal sync
// - match register takes 8 bits on its strobe
// - short words keep low match bits only
// - config byte captured by config load strobe
// - length select chooses 5 to 8 bits
// - disable ignores inputs, floats gated outputs; here master_clear still acts while disabled
// - disable gates strobes, clears, config, data, flags
// - host holds disable low; here CTRL bit 0 drives it, low at reset
// - right-justified data, upper zero, parity ninth
// - first sync shows match, later set received
// - odd, even or no parity after last bit
// - low clears reset error or received flags
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module scr_receiver
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial side
  input wire logic rx_bit_clock,
  input wire logic serial_in,
  input wire logic ext_sync_in,
  // parallel side
  scr_link_if.dev link
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [2:0] pins_q;
  logic bit_tick;
  logic bit_val;
  logic ext_mark;

  scr_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({ext_sync_in, serial_in, rx_bit_clock}),
    .q(pins_q),
    .rise(bit_tick)
  );

  assign bit_val = pins_q[1];
  assign ext_mark = pins_q[2];

  // ----------------------------------------------------------------
  // gated parallel inputs
  // ----------------------------------------------------------------
  logic en;
  logic cfg_load;
  logic match_load;
  logic err_clear;
  logic rx_clear;

  assign en = ~link.chip_io_disable;
  assign cfg_load = en & link.config_load_strobe;
  assign match_load = en & link.sync_match_load;
  assign err_clear = en & ~link.error_flags_clear_n;
  assign rx_clear = en & ~link.char_received_clear_n;

  // ----------------------------------------------------------------
  // control and match registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] match_q;
  logic [3:0] len_n;
  logic par_en;
  logic par_even;
  logic int_sync;
  logic [7:0] len_mask;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (cfg_load) begin
      cfg_q <= {1'b0, link.rx_mode_select, link.parity_even_select,
                link.parity_off, link.char_length_select};
    end
  end

  assign len_n = CHAR_MIN_LEN + {2'b00, cfg_q[CFG_LEN_LSB +: 2]};
  assign par_en = ~cfg_q[CFG_PAR_OFF];
  assign par_even = cfg_q[CFG_PAR_EVEN];
  assign int_sync = cfg_q[CFG_MODE_LSB +: 3] == MODE_SYNC_INT;
  assign len_mask = 8'hff >> (4'h8 - len_n);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_q <= MATCH_RESET;
    end else if (match_load) begin
      match_q <= link.sync_match_value & len_mask;
    end
  end

  // ----------------------------------------------------------------
  // shift register and character view
  // ----------------------------------------------------------------
  logic [7:0] shreg_q;
  logic [7:0] sr_next;
  logic [7:0] hunt_word;
  logic [7:0] data_word;
  logic par_bit;
  logic par_bad;

  // newest bit enters at the top, so the low bits line up after a shift
  assign sr_next = {bit_val, shreg_q[7:1]};
  assign hunt_word = sr_next >> (4'h8 - len_n);
  assign data_word = (par_en ? shreg_q : sr_next) >> (4'h8 - len_n);
  assign par_bit = par_en & bit_val;
  assign par_bad = par_en & ((^data_word ^ par_bit) == par_even);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shreg_q <= 8'h00;
    end else if (bit_tick) begin
      shreg_q <= sr_next;
    end
  end

  // ----------------------------------------------------------------
  // framing state
  // ----------------------------------------------------------------
  scr_state_e state_q;
  logic [3:0] remain_q;
  logic [3:0] frame_n;
  logic hit;
  logic xfer;

  assign frame_n = len_n + {3'b000, par_en};
  // a match is taken on any bit, with no alignment to earlier ones
  assign hit = bit_tick & (state_q == SCR_HUNT) &
               (int_sync ? (hunt_word == match_q) : ext_mark);
  assign xfer = bit_tick & (state_q == SCR_LOCKED) & (remain_q == 4'h1);

  always_ff @(posedge clk_sys) begin
    if (rst || link.master_clear) begin
      state_q <= SCR_HUNT;
      remain_q <= 4'h0;
    end else begin
      unique case (state_q)
        SCR_HUNT: begin
          if (hit && int_sync) begin
            // the sync character's own parity bit is skipped
            state_q <= SCR_LOCKED;
            remain_q <= frame_n + {3'b000, par_en};
          end else if (hit) begin
            // external mark flags the first bit of a character
            state_q <= SCR_LOCKED;
            remain_q <= frame_n - 4'h1;
          end
        end
        SCR_LOCKED: begin
          if (xfer) begin
            remain_q <= frame_n;
          end else if (bit_tick) begin
            remain_q <= remain_q - 4'h1;
          end
        end
        default: begin
          state_q <= SCR_HUNT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // holding register
  // ----------------------------------------------------------------
  logic [8:0] hold_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q <= 9'h000;
    end else if (xfer) begin
      hold_q <= {par_bit, data_word};
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic found_q;
  logic dr_q;
  logic pe_q;
  logic oe_q;

  always_ff @(posedge clk_sys) begin
    if (rst || link.master_clear) begin
      found_q <= 1'b0;
    end else if (hit) begin
      found_q <= 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst || link.master_clear) begin
      dr_q <= 1'b0;
    end else if (xfer) begin
      dr_q <= 1'b1;
    end else if (rx_clear) begin
      dr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || link.master_clear) begin
      pe_q <= 1'b0;
    end else if (xfer && par_bad) begin
      pe_q <= 1'b1;
    end else if (err_clear) begin
      pe_q <= 1'b0;
    end
  end

  // overrun: a new character lands while the last is still unread
  always_ff @(posedge clk_sys) begin
    if (rst || link.master_clear) begin
      oe_q <= 1'b0;
    end else if (xfer && dr_q && !rx_clear) begin
      oe_q <= 1'b1;
    end else if (err_clear) begin
      oe_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.out_oe = en;
  assign link.rx_char_out = hold_q;
  assign link.parity_err_flag = pe_q;
  assign link.framing_err_flag = 1'b0;
  assign link.overrun_err_flag = oe_q;
  assign link.char_received_flag = dr_q;
  assign link.sync_found = found_q;

endmodule : scr_receiver

/* rtl/scr_host.sv */
// scr_host: control logic that loads and unloads the receiver
// assumes: apb slave with zero wait states; same clk_sys as the receiver
module scr_host
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // receiver
  scr_link_if.host link
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic rd;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [1:0] ctrl_q;
  logic [7:0] match_q;
  logic [3:0] cmd_q;
  logic rd_data_q;
  logic [2:0] ist_q;
  logic [2:0] imask_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
      ctrl_q <= CTRL_RESET;
      match_q <= MATCH_RESET;
      imask_q <= IRQ_RESET;
    end else if (wr) begin
      if (paddr == ADDR_CFG) cfg_q <= pwdata[7:0];
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[1:0];
      if (paddr == ADDR_MATCH) match_q <= pwdata[7:0];
      if (paddr == ADDR_IRQ_MASK) imask_q <= pwdata[2:0];
    end
  end

  // command bits become one-cycle strobes; a data read frees the holder
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q <= 4'h0;
      rd_data_q <= 1'b0;
    end else begin
      cmd_q <= (wr && paddr == ADDR_CMD) ? pwdata[3:0] : 4'h0;
      rd_data_q <= rd && paddr == ADDR_DATA;
    end
  end

  assign link.rx_mode_select = cfg_q[CFG_MODE_LSB +: 3];
  assign link.char_length_select = cfg_q[CFG_LEN_LSB +: 2];
  assign link.parity_off = cfg_q[CFG_PAR_OFF];
  assign link.parity_even_select = cfg_q[CFG_PAR_EVEN];
  assign link.sync_match_value = match_q;
  assign link.config_load_strobe = cmd_q[CMD_LOAD_CFG];
  assign link.sync_match_load = cmd_q[CMD_LOAD_MATCH];
  assign link.error_flags_clear_n = ~cmd_q[CMD_CLR_ERR];
  assign link.char_received_clear_n = ~(cmd_q[CMD_CLR_RX] | rd_data_q);
  assign link.chip_io_disable = ctrl_q[CTRL_DISABLE];
  assign link.master_clear = ctrl_q[CTRL_MCLEAR];

  // ----------------------------------------------------------------
  // receiver status, floating outputs read as zero
  // ----------------------------------------------------------------
  logic [8:0] rx_char;
  logic [4:0] status;
  logic [2:0] ev_now;
  logic [2:0] ev_prev_q;

  assign rx_char = link.out_oe ? link.rx_char_out : 9'h000;
  assign status = {link.sync_found,
                   link.out_oe & link.overrun_err_flag,
                   link.out_oe & link.framing_err_flag,
                   link.out_oe & link.parity_err_flag,
                   link.char_received_flag};
  assign ev_now = {status[3] | status[2] | status[1], status[4], status[0]};

  // ----------------------------------------------------------------
  // interrupt status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev_prev_q <= IRQ_RESET;
      ist_q <= IRQ_RESET;
    end else begin
      ev_prev_q <= ev_now;
      ist_q <= (ist_q & ~((wr && paddr == ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0)) |
               (ev_now & ~ev_prev_q);
    end
  end

  assign irq = |(ist_q & imask_q);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      unique case (paddr)
        ADDR_CFG: prdata <= {24'h00_0000, cfg_q};
        ADDR_CTRL: prdata <= {30'h0000_0000, ctrl_q};
        ADDR_MATCH: prdata <= {24'h00_0000, match_q};
        ADDR_DATA: prdata <= {23'h00_0000, rx_char};
        ADDR_STATUS: prdata <= {27'h000_0000, status};
        ADDR_IRQ_STAT: prdata <= {29'h0000_0000, ist_q};
        ADDR_IRQ_MASK: prdata <= {29'h0000_0000, imask_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : scr_host

/* tb/scr_link_props.sv */
// scr_link_props: assertions on the link between host and receiver
// assumes: all link signals on clk_sys; rst synchronous, active high
module scr_link_props
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host to receiver
  input wire logic config_load_strobe,
  input wire logic parity_off,
  input wire logic [1:0] char_length_select,
  input wire logic chip_io_disable,
  input wire logic master_clear,
  input wire logic char_received_clear_n,
  // receiver to host
  input wire logic [8:0] rx_char_out,
  input wire logic parity_err_flag,
  input wire logic overrun_err_flag,
  input wire logic out_oe,
  input wire logic char_received_flag,
  input wire logic sync_found
);
  logic [1:0] len_q;
  logic poff_q;
  // --------
  // copy of the loaded length and parity setting
  // --------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      len_q <= CFG_RESET[1:0];
      poff_q <= CFG_RESET[CFG_PAR_OFF];
    end else if (config_load_strobe && !chip_io_disable) begin
      len_q <= char_length_select;
      poff_q <= parity_off;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_load;
    $rose(char_received_flag);
  endsequence
  property p_oe; out_oe == !chip_io_disable; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_gate;
    chip_io_disable && !master_clear |=> !$fell(parity_err_flag) && !$fell(overrun_err_flag);
  endproperty
  a_gate: assert property (p_gate) else $error("error flags cleared while disabled");
  property p_just; s_load |-> (rx_char_out[7:0] >> (len_q + 4'd5)) == 8'h00; endproperty
  a_just: assert property (p_just) else $error("upper data bits set");
  property p_nopar; poff_q ##0 s_load |-> !rx_char_out[8] && !$rose(parity_err_flag); endproperty
  a_nopar: assert property (p_nopar) else $error("parity seen while off");
  property p_first; $rose(sync_found) |-> !char_received_flag; endproperty
  a_first: assert property (p_first) else $error("sync char flagged");
  property p_after; s_load |-> $past(sync_found); endproperty
  a_after: assert property (p_after) else $error("char before sync");
  property p_lock; sync_found && !master_clear |=> sync_found; endproperty
  a_lock: assert property (p_lock) else $error("sync lost");
  property p_mclr;
    master_clear |=> !(sync_found || char_received_flag || parity_err_flag || overrun_err_flag);
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear missed");
  property p_sticky;
    char_received_flag && (char_received_clear_n || chip_io_disable) && !master_clear
      |=> char_received_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("received flag dropped");
endmodule : scr_link_props

/* tb/test_sync_char_receiver_setup.sv */
// test_sync_char_receiver_setup: host and receiver joined by the link
// assumes: apb on clk_sys; the bench makes the bit clock and serial data
module test_sync_char_receiver_setup
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rx_bit_clock = 1'b0;
  logic serial_in = 1'b0;
  logic ext_sync_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] seed = 32'h0f50;
  logic poff = 1'b1;
  logic even = 1'b0;
  logic pb = 1'b0;
  int n = 8;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  scr_link_if link ();
  scr_receiver scr_receiver_i (.clk_sys(clk_sys), .rst(rst), .rx_bit_clock(rx_bit_clock),
    .serial_in(serial_in), .ext_sync_in(ext_sync_in), .link(link.dev));
  scr_host scr_host_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link.host));
  scr_link_props scr_link_props_i (.clk_sys(clk_sys), .rst(rst),
    .config_load_strobe(link.config_load_strobe), .parity_off(link.parity_off),
    .char_length_select(link.char_length_select), .chip_io_disable(link.chip_io_disable),
    .master_clear(link.master_clear), .char_received_clear_n(link.char_received_clear_n),
    .rx_char_out(link.rx_char_out), .parity_err_flag(link.parity_err_flag),
    .overrun_err_flag(link.overrun_err_flag), .out_oe(link.out_oe),
    .char_received_flag(link.char_received_flag), .sync_found(link.sync_found));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      test_done();
    end
  end
  // --------
  // helpers
  // --------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // no window mixing the preamble and the sync char may match it early
  function automatic logic clean(input logic [7:0] m, input int len);
    logic [7:0] mk;
    logic [7:0] w;
    clean = 1'b1;
    mk = 8'hff >> (8 - len);
    for (int k = 1; k < len; k++) begin
      w = (m << (len - k)) | (m[len-1] ? 8'h00 : 8'hff >> (8 - len + k));
      if ((w & mk) == (m & mk)) begin
        clean = 1'b0;
      end
    end
  endfunction : clean
  function automatic logic [31:0] stat(input logic rx, input logic pe, input logic ov);
    return {27'h0, 1'b1, ov, 1'b0, pe, rx};
  endfunction : stat
  function automatic logic [31:0] exp_data(input logic [7:0] d);
    return {23'h0, pb & !poff, d};
  endfunction : exp_data
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: addr %h got %h expected %h", $time, paddr, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd
  // one bit per 31 clocks, the closest whole count to 125 ns
  task automatic bit_out(input logic b, input logic mark);
    serial_in <= b;
    ext_sync_in <= mark;
    repeat (16) @(posedge clk_sys);
    rx_bit_clock <= 1'b1;
    repeat (15) @(posedge clk_sys);
    rx_bit_clock <= 1'b0;
  endtask : bit_out
  // data bits lsb first, then parity; line shows the inverse once idle
  task automatic send_char(input logic [7:0] d, input logic bad, input logic mark);
    pb = ^d ^ !even ^ bad;
    for (int i = 0; i < n; i++) begin
      bit_out(d[i], mark && i == 0);
    end
    if (!poff) begin
      bit_out(pb, 1'b0);
    end
    serial_in <= ~serial_in;
    @(posedge clk_sys);
  endtask : send_char
  task automatic hunt(input logic [7:0] m);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      bit_out(!m[n-1], 1'b0);
    end
    rd(ADDR_STATUS, 32'h0, 1'b0);
    for (int i = 0; i < n; i++) begin
      bit_out(m[i], 1'b0);
    end
    rd(ADDR_STATUS, 32'h10, 1'b0);
    r = rnd();
    if (!poff) begin
      bit_out(r[0], 1'b0);
    end
  endtask : hunt
  task automatic setup(input logic [7:0] cfg, input logic [7:0] m);
    wr(ADDR_CFG, {24'h0, cfg});
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_MATCH, {24'h0, m});
    wr(ADDR_CMD, 32'h2);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CTRL, 32'h0);
    n = 5 + cfg[1:0];
    poff = cfg[2];
    even = cfg[3];
  endtask : setup
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // --------
  // main sequence
  // --------
  initial begin
    logic [7:0] mk;
    logic [7:0] d;
    logic [31:0] r;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CFG, {24'h0, CFG_RESET}, 1'b0);
    rd(ADDR_STATUS, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    $display("test reset done");
    for (int t = 0; t < 8; t++) begin
      mk = 8'hff >> (3 - t[1:0]);
      do begin
        r = rnd();
      end while (!clean(r[7:0] & mk, 5 + t[1:0]));
      setup({1'b0, MODE_SYNC_INT, t % 3 == 1, t % 3 == 2, t[1:0]}, r[7:0]);
      hunt(r[7:0] & mk);
      for (int k = 0; k < 3; k++) begin
        r = rnd();
        d = r[7:0] & mk;
        send_char(d, k == 1 && !poff, 1'b0);
        rd(ADDR_STATUS, stat(1'b1, k == 1 && !poff, 1'b0), 1'b0);
        rd(ADDR_DATA, exp_data(d), 1'b0);
        wr(ADDR_CMD, 32'h4);
      end
      r = rnd();
      send_char(r[7:0] & mk, 1'b0, 1'b0);
      d = r[15:8] & mk;
      send_char(d, 1'b0, 1'b0);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_DATA, 32'h0, 1'b0);
      wr(ADDR_CMD, 32'hc);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_STATUS, stat(1'b1, 1'b0, 1'b1), 1'b0);
      rd(ADDR_DATA, exp_data(d), 1'b0);
      wr(ADDR_CMD, 32'h4);
    end
    $display("test modes done");
    setup(8'h74, 8'hff);
    wr(ADDR_CFG, 32'h77);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CTRL, 32'h0);
    n = 8;
    hunt(8'h1f);
    $display("test match mask done");
    setup(8'h07, 8'h00);
    r = rnd();
    for (int i = 0; i < 3; i++) begin
      bit_out(r[i], 1'b0);
    end
    send_char(r[15:8], 1'b0, 1'b1);
    rd(ADDR_STATUS, stat(1'b1, 1'b0, 1'b0), 1'b0);
    wr(ADDR_CMD, 32'h8);
    rd(ADDR_STATUS, stat(1'b0, 1'b0, 1'b0), 1'b0);
    rd(ADDR_DATA, exp_data(r[15:8]), 1'b0);
    $display("test external sync done");
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h0);
    send_char(r[23:16], 1'b0, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h1, 1'b0);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_DATA, exp_data(r[23:16]), 1'b0);
    wr(ADDR_IRQ_STAT, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h0, 1'b0);
    $display("test irq done");
    test_done();
  end
endmodule : test_sync_char_receiver_setup
